/* logic/cts_err_hyst.sv */
// error counter trigger with hysteresis for warning and passive levels
// assumes counters come straight from the protocol engine each cycle
`timescale 1ns/1ns
`default_nettype none
module cts_err_hyst (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // error counters
    input wire logic [7:0] txErrCount,
    input wire logic [7:0] rxErrCount,
    // one-cycle pulse when any trigger fires
    output logic fire
);

    // armed flags: index 0 warn tx, 1 warn rx, 2 passive tx, 3 passive rx
    logic [3:0] armed_q;
    logic [3:0] hit;
    logic [3:0] low;

    // trigger and re-arm comparisons
    always_comb
    begin
        hit[0] = txErrCount >= cts_pkg::ERR_WARN_FIRE;
        hit[1] = rxErrCount >= cts_pkg::ERR_WARN_FIRE;
        hit[2] = txErrCount >= cts_pkg::ERR_PASS_FIRE;
        hit[3] = rxErrCount >= cts_pkg::ERR_PASS_FIRE;
        low[0] = txErrCount <= cts_pkg::ERR_WARN_REARM;
        low[1] = rxErrCount <= cts_pkg::ERR_WARN_REARM;
        low[2] = txErrCount <= cts_pkg::ERR_PASS_REARM;
        low[3] = rxErrCount <= cts_pkg::ERR_PASS_REARM;
    end

    // disarm on firing, re-arm once well below the level
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            armed_q <= 4'hF;
        else
            armed_q <= (armed_q & ~hit) | low;
    end

    // event pulse on any armed trigger
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            fire <= 1'b0;
        else
            fire <= |(armed_q & hit);
    end

endmodule
`default_nettype wire

/* logic/cts_pkg.sv */
// constants and types shared by the transmit message scheduler
// assumes one device clock, where one clock period stands for one oscillator period
package cts_pkg;

    // ----------------------------------------------------------------
    // identifier byte layout
    // ----------------------------------------------------------------
    localparam int SIDL_SID_MSB = 7;
    localparam int SIDL_SID_LSB = 5;
    localparam int SIDL_EXT_FLAG = 3;
    localparam int SIDL_EID_MSB = 1;

    // ----------------------------------------------------------------
    // scheduled report timing, in oscillator periods
    // ----------------------------------------------------------------
    localparam int unsigned SCHED_MIN_TOSC = 4096;
    localparam int unsigned TOSC_PER_CLK = 1;
    localparam int unsigned BASE_RATE0_CYC = SCHED_MIN_TOSC / TOSC_PER_CLK;
    localparam int unsigned BASE_RATE1_CYC = BASE_RATE0_CYC * 16;
    localparam int unsigned BASE_RATE2_CYC = BASE_RATE1_CYC * 16;
    localparam int unsigned BASE_RATE3_CYC = BASE_RATE2_CYC * 16;
    localparam int TIMER_W = 28;

    // ----------------------------------------------------------------
    // error counter trigger and re-arm levels
    // ----------------------------------------------------------------
    localparam logic [7:0] ERR_WARN_FIRE = 8'h60;
    localparam logic [7:0] ERR_WARN_REARM = 8'h4F;
    localparam logic [7:0] ERR_PASS_FIRE = 8'h80;
    localparam logic [7:0] ERR_PASS_REARM = 8'h6F;

    // ----------------------------------------------------------------
    // data length codes of the predefined messages
    // ----------------------------------------------------------------
    localparam logic [3:0] DLC_NONE = 4'h0;
    localparam logic [3:0] DLC_EDGE = 4'h2;
    localparam logic [3:0] DLC_ERROR = 4'h3;
    localparam logic [3:0] DLC_ANALOG = 4'h6;

    // ----------------------------------------------------------------
    // pin counts
    // ----------------------------------------------------------------
    localparam int NUM_PINS = 8;
    localparam int NUM_ANALOG = 4;

    // message kinds
    typedef enum logic [2:0] {
        KIND_ON_BUS,
        KIND_RESPONSE,
        KIND_EDGE,
        KIND_ANALOG,
        KIND_ACK,
        KIND_OVERFLOW,
        KIND_ERROR,
        KIND_SCHEDULED
    } cts_kind_t;

endpackage

/* logic/cts_sched_timer.sv */
// scheduled report interval timer: base rate times multiplier plus one
// assumes the enable is a level from the schedule control register
`timescale 1ns/1ns
`default_nettype none
module cts_sched_timer #(
    parameter int unsigned BASE0 = cts_pkg::BASE_RATE0_CYC,
    parameter int unsigned BASE1 = cts_pkg::BASE_RATE1_CYC,
    parameter int unsigned BASE2 = cts_pkg::BASE_RATE2_CYC,
    parameter int unsigned BASE3 = cts_pkg::BASE_RATE3_CYC
)(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // configuration
    input wire logic enable,
    input wire logic [1:0] baseRate,
    input wire logic [3:0] multiplier,
    // one-cycle pulse at each interval end
    output logic tick
);

    logic [cts_pkg::TIMER_W-1:0] preCnt_q;
    logic [3:0] mulCnt_q;
    logic [cts_pkg::TIMER_W-1:0] baseLast;
    logic preWrap;

    // last count of the selected base period
    always_comb
    begin
        case (baseRate)
            2'd0: baseLast = cts_pkg::TIMER_W'(BASE0 - 1);
            2'd1: baseLast = cts_pkg::TIMER_W'(BASE1 - 1);
            2'd2: baseLast = cts_pkg::TIMER_W'(BASE2 - 1);
            default: baseLast = cts_pkg::TIMER_W'(BASE3 - 1);
        endcase
    end

    assign preWrap = (preCnt_q >= baseLast);

    // base period prescaler, held clear while disabled
    always_ff @(posedge clk_sys)
    begin
        if (!nrst || !enable)
            preCnt_q <= '0;
        else if (preWrap)
            preCnt_q <= '0;
        else
            preCnt_q <= preCnt_q + 1'b1;
    end

    // multiplier count of base periods
    always_ff @(posedge clk_sys)
    begin
        if (!nrst || !enable)
            mulCnt_q <= '0;
        else if (preWrap)
            mulCnt_q <= (mulCnt_q >= multiplier) ? 4'h0 : mulCnt_q + 4'h1;
    end

    // pulse only while enabled
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            tick <= 1'b0;
        else
            tick <= enable && preWrap && (mulCnt_q >= multiplier);
    end

endmodule
`default_nettype wire

/* logic/cts_tx_scheduler.sv */
// transmit message scheduler: picks the next predefined message and its identifier
// assumes a protocol engine that takes a held request and answers done or fail
`timescale 1ns/1ns
`default_nettype none
module cts_tx_scheduler #(
    parameter int unsigned BASE0 = cts_pkg::BASE_RATE0_CYC,
    parameter int unsigned BASE1 = cts_pkg::BASE_RATE1_CYC,
    parameter int unsigned BASE2 = cts_pkg::BASE_RATE2_CYC,
    parameter int unsigned BASE3 = cts_pkg::BASE_RATE3_CYC
)(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // device state
    input wire logic onBusReady,
    // identifier bytes, index 0 scheduled, 1 handshake/error, 2 auto report
    input wire logic [7:0] txIdentStdHigh [3],
    input wire logic [7:0] txIdentStdLow [3],
    input wire logic [7:0] txIdentExtMid [3],
    input wire logic [7:0] txIdentExtLow [3],
    // schedule control register fields
    input wire logic [1:0] scheduleBaseRate,
    input wire logic [3:0] scheduleMultiplier,
    input wire logic scheduleContentSelect,
    input wire logic scheduleEnableBit,
    // option register two fields
    input wire logic ackVsOverflowSelect,
    input wire logic transmitOnErrorEnable,
    // error state
    input wire logic [7:0] txErrCount,
    input wire logic [7:0] rxErrCount,
    input wire logic [7:0] errorFlagReg,
    // pin registers
    input wire logic [7:0] pinInputs,
    input wire logic [7:0] pinDirectionReg,
    input wire logic [7:0] pinReportEnableReg,
    input wire logic [7:0] pinEdgePolarityReg,
    input wire logic [3:0] pinAnalogDigitalSelect,
    // analog results and thresholds
    input wire logic [9:0] analogResult [4],
    input wire logic [9:0] thresholdCompare [4],
    input wire logic [3:0] thresholdPolarity,
    // receive side events
    input wire logic inputCommandDone,
    input wire logic rxOverflow,
    input wire logic informationRequest,
    input wire logic [28:0] responseIdent,
    input wire logic responseExtended,
    input wire logic [3:0] responseDlc,
    input wire logic [63:0] responseData,
    // transmit request to protocol engine
    output logic txReq,
    output logic [28:0] txIdent,
    output logic txExtended,
    output logic [3:0] txDlc,
    output logic [63:0] txData,
    output logic [2:0] txKind,
    input wire logic txDone,
    input wire logic txFail
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // builds the frame identifier from its four bytes
    function automatic logic [28:0] buildIdent(input logic [7:0] hi, input logic [7:0] lo,
                                               input logic [7:0] mid, input logic [7:0] lw);
        logic [10:0] sid;
        sid = {hi, lo[cts_pkg::SIDL_SID_MSB:cts_pkg::SIDL_SID_LSB]};
        if (lo[cts_pkg::SIDL_EXT_FLAG])
            buildIdent = {sid, lo[cts_pkg::SIDL_EID_MSB:0], mid, lw};
        else
            buildIdent = {18'h0_0000, sid};
    endfunction

    // analog register payload: pins, high bytes, packed low bits
    function automatic logic [63:0] analogPayload(input logic [7:0] pins, input logic [9:0] a0,
                                                  input logic [9:0] a1, input logic [9:0] a2,
                                                  input logic [9:0] a3);
        analogPayload = {pins, a0[9:2], a1[9:2], a2[9:2], a3[9:2],
                         a3[1:0], a2[1:0], a1[1:0], a0[1:0], 16'h0000};
    endfunction

    // ----------------------------------------------------------------
    // event sources
    // ----------------------------------------------------------------

    logic schedTick;
    logic errFire;
    logic [7:0] pinPrev_q;
    logic [3:0] abovePrev_q;
    logic [3:0] above;
    logic [7:0] pinDigital;
    logic [7:0] pinEdgeHit;
    logic [3:0] analogHit;
    logic primed_q;

    cts_sched_timer #(
        .BASE0(BASE0),
        .BASE1(BASE1),
        .BASE2(BASE2),
        .BASE3(BASE3)
    ) uTimer (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .enable(scheduleEnableBit && onBusReady),
        .baseRate(scheduleBaseRate),
        .multiplier(scheduleMultiplier),
        .tick(schedTick)
    );

    cts_err_hyst uHyst (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .txErrCount(txErrCount),
        .rxErrCount(rxErrCount),
        .fire(errFire)
    );

    // digital pins: analog-capable pins count only when set digital
    assign pinDigital = pinDirectionReg & {4'hF, pinAnalogDigitalSelect};

    // selected edge per pin, polarity 0 means falling
    assign pinEdgeHit = primed_q ? (pinDigital & pinReportEnableReg &
                        ((pinEdgePolarityReg & pinInputs & ~pinPrev_q) |
                         (~pinEdgePolarityReg & ~pinInputs & pinPrev_q))) : 8'h00;

    // threshold crossing per analog channel, polarity 1 means going above
    always_comb
    begin
        for (int i = 0; i < cts_pkg::NUM_ANALOG; i++)
        begin
            above[i] = analogResult[i] > thresholdCompare[i];
            analogHit[i] = primed_q && pinDirectionReg[i] && !pinAnalogDigitalSelect[i] &&
                           pinReportEnableReg[i] &&
                           (thresholdPolarity[i] ? (above[i] && !abovePrev_q[i])
                                                 : (!above[i] && abovePrev_q[i]));
        end
    end

    // previous samples for edge and crossing detection
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            pinPrev_q <= 8'h00;
            abovePrev_q <= 4'h0;
            primed_q <= 1'b0;
        end
        else
        begin
            pinPrev_q <= pinInputs;
            abovePrev_q <= above;
            primed_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // pending flags
    // ----------------------------------------------------------------

    logic [7:0] pend_q;
    logic [7:0] pendSet;
    logic [7:0] pendClr;
    logic [28:0] rspIdent_q;
    logic rspExt_q;
    logic [3:0] rspDlc_q;

    // event to pending bit, indexed by message kind
    always_comb
    begin
        pendSet = 8'h00;
        pendSet[cts_pkg::KIND_RESPONSE] = informationRequest;
        pendSet[cts_pkg::KIND_EDGE] = |pinEdgeHit;
        pendSet[cts_pkg::KIND_ANALOG] = |analogHit;
        pendSet[cts_pkg::KIND_ACK] = inputCommandDone && ackVsOverflowSelect;
        pendSet[cts_pkg::KIND_OVERFLOW] = rxOverflow && !ackVsOverflowSelect;
        pendSet[cts_pkg::KIND_ERROR] = errFire && transmitOnErrorEnable;
        pendSet[cts_pkg::KIND_SCHEDULED] = schedTick;
    end

    // set wins over clear; announcement pending from reset
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            pend_q <= 8'h01 << cts_pkg::KIND_ON_BUS;
        else
            pend_q <= (pend_q & ~pendClr) | pendSet;
    end

    // response frame parameters, latched with the request
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            rspIdent_q <= '0;
            rspExt_q <= 1'b0;
            rspDlc_q <= 4'h0;
        end
        else if (informationRequest && !pend_q[cts_pkg::KIND_RESPONSE])
        begin
            rspIdent_q <= responseIdent;
            rspExt_q <= responseExtended;
            rspDlc_q <= responseDlc;
        end
    end

    // ----------------------------------------------------------------
    // selection and request
    // ----------------------------------------------------------------

    typedef enum logic {ST_IDLE, ST_SEND} cts_state_t;
    cts_state_t state_q;
    cts_pkg::cts_kind_t pick;
    logic pickValid;
    logic [1:0] identSel;

    // fixed priority; announcement blocks all others
    always_comb
    begin
        pickValid = onBusReady;
        pick = cts_pkg::KIND_SCHEDULED;
        if (pend_q[cts_pkg::KIND_ON_BUS])
            pick = cts_pkg::KIND_ON_BUS;
        else if (pend_q[cts_pkg::KIND_RESPONSE])
            pick = cts_pkg::KIND_RESPONSE;
        else if (pend_q[cts_pkg::KIND_EDGE])
            pick = cts_pkg::KIND_EDGE;
        else if (pend_q[cts_pkg::KIND_ANALOG])
            pick = cts_pkg::KIND_ANALOG;
        else if (pend_q[cts_pkg::KIND_ACK])
            pick = cts_pkg::KIND_ACK;
        else if (pend_q[cts_pkg::KIND_OVERFLOW])
            pick = cts_pkg::KIND_OVERFLOW;
        else if (pend_q[cts_pkg::KIND_ERROR])
            pick = cts_pkg::KIND_ERROR;
        else if (!pend_q[cts_pkg::KIND_SCHEDULED])
            pickValid = 1'b0;
    end

    // identifier slot per kind
    always_comb
    begin
        case (pick)
            cts_pkg::KIND_EDGE,
            cts_pkg::KIND_ANALOG: identSel = 2'd2;
            cts_pkg::KIND_ACK,
            cts_pkg::KIND_OVERFLOW,
            cts_pkg::KIND_ERROR: identSel = 2'd1;
            default: identSel = 2'd0;
        endcase
    end

    // clear the pending bit of the kind that went out
    assign pendClr = (state_q == ST_SEND && txDone) ? (8'h01 << txKind) : 8'h00;

    // request state: held until done, failure goes back to arbitration
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            state_q <= ST_IDLE;
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (pickValid)
                        state_q <= ST_SEND;
                ST_SEND:
                    if (txDone || txFail)
                        state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign txReq = (state_q == ST_SEND);

    // frame fields captured at launch, from live registers except the latched response identifier, format and length
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            txIdent <= '0;
            txExtended <= 1'b0;
            txDlc <= 4'h0;
            txData <= '0;
            txKind <= 3'd0;
        end
        else if (state_q == ST_IDLE && pickValid)
        begin
            txKind <= pick;
            txIdent <= buildIdent(txIdentStdHigh[identSel], txIdentStdLow[identSel],
                                  txIdentExtMid[identSel], txIdentExtLow[identSel]);
            txExtended <= txIdentStdLow[identSel][cts_pkg::SIDL_EXT_FLAG];
            txData <= '0;
            txDlc <= cts_pkg::DLC_NONE;
            case (pick)
                cts_pkg::KIND_RESPONSE:
                begin
                    txIdent <= rspIdent_q;
                    txExtended <= rspExt_q;
                    txDlc <= rspDlc_q;
                    txData <= responseData;
                end
                cts_pkg::KIND_EDGE:
                begin
                    txDlc <= cts_pkg::DLC_EDGE;
                    txData <= {pinDirectionReg, pinInputs, 48'h0000_0000_0000};
                end
                cts_pkg::KIND_ANALOG:
                begin
                    txDlc <= cts_pkg::DLC_ANALOG;
                    txData <= analogPayload(pinInputs, analogResult[0], analogResult[1],
                                            analogResult[2], analogResult[3]);
                end
                cts_pkg::KIND_ERROR:
                begin
                    txDlc <= cts_pkg::DLC_ERROR;
                    txData <= {txErrCount, rxErrCount, errorFlagReg, 40'h00_0000_0000};
                end
                cts_pkg::KIND_SCHEDULED:
                    if (scheduleContentSelect)
                    begin
                        txDlc <= cts_pkg::DLC_ANALOG;
                        txData <= analogPayload(pinInputs, analogResult[0], analogResult[1],
                                                analogResult[2], analogResult[3]);
                    end
                default: txDlc <= cts_pkg::DLC_NONE;
            endcase
        end
    end

endmodule
`default_nettype wire

/* verification/cts_engine_model.sv */
// protocol engine stand-in
// assumes txReq is held until answered
`timescale 1ns/1ns
`default_nettype none
module cts_engine_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // request and behaviour
    input wire logic txReq,
    input wire logic [3:0] latency,
    input wire logic failNow,
    // answer pulses
    output logic txDone,
    output logic txFail
);
    logic [3:0] waitCnt_q;
    // count latency, then one done or fail pulse
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            waitCnt_q <= 4'h0;
            txDone <= 1'b0;
            txFail <= 1'b0;
        end
        else
        begin
            txDone <= 1'b0;
            txFail <= 1'b0;
            if (!txReq || txDone || txFail)
                waitCnt_q <= 4'h0;
            else if (waitCnt_q >= latency)
            begin
                txDone <= !failNow;
                txFail <= failNow;
            end
            else
                waitCnt_q <= waitCnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* verification/cts_tx_scheduler_properties.sv */
// assertions on the scheduler's transmit request port
// assumes binding into cts_tx_scheduler, one clock domain
`timescale 1ns/1ns
`default_nettype none
module cts_tx_scheduler_properties (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // configuration
    input wire logic onBusReady,
    input wire logic scheduleContentSelect,
    input wire logic ackVsOverflowSelect,
    input wire logic [7:0] txIdentStdHigh [3],
    input wire logic [7:0] txIdentStdLow [3],
    input wire logic [7:0] txIdentExtMid [3],
    input wire logic [7:0] txIdentExtLow [3],
    // request port
    input wire logic txReq,
    input wire logic [28:0] txIdent,
    input wire logic txExtended,
    input wire logic [3:0] txDlc,
    input wire logic [2:0] txKind,
    input wire logic txDone,
    input wire logic txFail
);
    int slot;
    logic [7:0] sl;
    // identifier slot of the kind on the port
    always_comb
    begin
        slot = (txKind inside {3'h0, 3'h7}) ? 0 : (txKind inside {3'h2, 3'h3}) ? 2 : 1;
        sl = txIdentStdLow[slot];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_hold;
        txReq && !txDone && !txFail |=> txReq && $stable(txIdent) && $stable(txKind) && $stable(txDlc);
    endproperty
    a_hold: assert property (p_hold) else $error("request not held");
    property p_gap;
        txReq && (txDone || txFail) |=> !txReq;
    endproperty
    a_gap: assert property (p_gap) else $error("no idle cycle");
    property p_bus;
        !onBusReady && !txReq |=> !txReq;
    endproperty
    a_bus: assert property (p_bus) else $error("launch off bus");
    property p_quiet;
        txReq && txKind inside {3'h0, 3'h4, 3'h5} |-> txDlc == 4'h0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("data on empty message");
    property p_sched;
        txReq && txKind == 3'h7 |-> txDlc == (scheduleContentSelect ? 4'h6 : 4'h0);
    endproperty
    a_sched: assert property (p_sched) else $error("scheduled length");
    property p_sel;
        txReq && txKind inside {3'h4, 3'h5} |-> ackVsOverflowSelect == (txKind == 3'h4);
    endproperty
    a_sel: assert property (p_sel) else $error("wrong handshake kind");
    property p_ident;
        txReq && txKind != 3'h1 |-> txExtended == sl[3] && (sl[3] ? txIdent == {txIdentStdHigh[slot], sl[7:5],
            sl[1:0], txIdentExtMid[slot], txIdentExtLow[slot]} : txIdent[10:0] == {txIdentStdHigh[slot], sl[7:5]});
    endproperty
    a_ident: assert property (p_ident) else $error("identifier wrong");
    property p_auto;
        txReq && txKind inside {3'h2, 3'h3, 3'h6} |-> txDlc == (txKind == 3'h2 ? 4'h2 : txKind == 3'h3 ? 4'h6 : 4'h3);
    endproperty
    a_auto: assert property (p_auto) else $error("report length");
endmodule
bind cts_tx_scheduler cts_tx_scheduler_properties u_props (.*);
`default_nettype wire

/* verification/cts_tx_scheduler_tb_top.sv */
// self-checking bench for the transmit message scheduler
// assumes short base rates 4, 8, 16, 32 cycles
`timescale 1ns/1ns
`default_nettype none
module cts_tx_scheduler_tb_top;
    logic clk_sys, nrst, onBusReady, scheduleContentSelect, scheduleEnableBit, ackVsOverflowSelect;
    logic transmitOnErrorEnable, inputCommandDone, rxOverflow, informationRequest, responseExtended;
    logic txReq, txExtended, txDone, txFail, failNow, prevReq;
    logic [7:0] txIdentStdHigh [3], txIdentStdLow [3], txIdentExtMid [3], txIdentExtLow [3];
    logic [1:0] scheduleBaseRate;
    logic [3:0] scheduleMultiplier, pinAnalogDigitalSelect, thresholdPolarity, responseDlc, txDlc, latency;
    logic [7:0] txErrCount, rxErrCount, errorFlagReg, pinInputs, pinDirectionReg, pinReportEnableReg;
    logic [7:0] pinEdgePolarityReg;
    logic [9:0] analogResult [4], thresholdCompare [4];
    logic [28:0] responseIdent, txIdent;
    logic [63:0] responseData, txData;
    logic [2:0] txKind;
    logic [2:0] expQ [$];
    int schedT [$];
    int errTotal, numChecks, cycNow, base, mult;
    // clock and design
    always #10 clk_sys = ~clk_sys;
    cts_tx_scheduler #(.BASE0(4), .BASE1(8), .BASE2(16), .BASE3(32)) DUT (.*);
    cts_engine_model u_eng (.*);
    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic drain(string name);
        for (int i = 0; i < 3000 && (expQ.size() != 0 || txReq); i++)
            step(1);
        step(2);
        check("pending", expQ.size(), 0);
        $display("test %s done", name);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // expected length per kind
    function automatic logic [3:0] expDlc(logic [2:0] k);
        case (k)
            3'h1: return responseDlc;
            3'h2: return cts_pkg::DLC_EDGE;
            3'h3: return cts_pkg::DLC_ANALOG;
            3'h6: return cts_pkg::DLC_ERROR;
            3'h7: return scheduleContentSelect ? cts_pkg::DLC_ANALOG : 4'h0;
            default: return 4'h0;
        endcase
    endfunction
    // check each launch
    always @(negedge clk_sys)
    begin
        cycNow++;
        if (nrst && txReq && !prevReq)
        begin
            if (expQ.size() == 0)
                check("spare_launch", 1, 0);
            else
            begin
                check("kind", txKind, expQ[0]);
                check("dlc", txDlc, expDlc(expQ.pop_front()));
            end
            if (txKind == 3'h7)
                schedT.push_back(cycNow);
            if (txKind == 3'h6)
                check("err_data", txData[63:40], {txErrCount, rxErrCount, errorFlagReg});
            if (txKind == 3'h2)
                check("edge_data", txData[63:48], {pinDirectionReg, pinInputs});
        end
        prevReq = txReq;
    end
    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        errTotal++;
        finish_test();
    end
    // main sequence
    initial
    begin
        clk_sys = 0;
        nrst = 0;
        {onBusReady, scheduleEnableBit, inputCommandDone, rxOverflow, informationRequest, failNow} = '0;
        {ackVsOverflowSelect, transmitOnErrorEnable, latency} = {2'b11, 4'h1};
        void'($urandom(86));
        for (int i = 0; i < 3; i++)
            {txIdentStdHigh[i], txIdentStdLow[i], txIdentExtMid[i], txIdentExtLow[i]} = $urandom;
        for (int i = 0; i < 4; i++)
            {analogResult[i], thresholdCompare[i]} = {10'h100, 10'h200};
        {scheduleBaseRate, scheduleMultiplier, scheduleContentSelect} = '0;
        {txErrCount, rxErrCount, errorFlagReg} = {8'h00, 8'($urandom_range(60)), 8'($urandom)};
        {pinInputs, pinDirectionReg, pinReportEnableReg, pinEdgePolarityReg} = 32'hFFFF_1200;
        {pinAnalogDigitalSelect, thresholdPolarity} = 8'hD2;
        {responseIdent, responseExtended, responseDlc} = {29'($urandom), 1'b0, 4'h5};
        responseData = {$urandom, $urandom};
        repeat (8) @(posedge clk_sys);
        #2 nrst = 1;
        // announcement first
        step(3);
        inputCommandDone = 1;
        step(1);
        inputCommandDone = 0;
        step(5);
        check("early_req", txReq, 0);
        expQ = '{3'h0, 3'h4};
        onBusReady = 1;
        drain("on_bus");
        // four kinds pending together
        onBusReady = 0;
        {informationRequest, inputCommandDone, pinInputs[4], txErrCount} = {3'b110, 8'h60};
        step(1);
        {informationRequest, inputCommandDone} = 2'b00;
        step(3);
        expQ = '{3'h1, 3'h2, 3'h4, 3'h6};
        onBusReady = 1;
        drain("priority");
        // hysteresis, no report until re-armed
        txErrCount = 8'h64;
        step(3);
        txErrCount = 8'h50;
        step(3);
        txErrCount = 8'h61;
        step(3);
        {pinInputs[4], pinInputs[5]} = 2'b10;
        txErrCount = 8'h4F;
        step(3);
        expQ = '{3'h6};
        txErrCount = 8'h60;
        drain("warn_rearm");
        expQ = '{3'h6};
        txErrCount = 8'h80;
        drain("passive");
        // overflow with one failed try
        {ackVsOverflowSelect, failNow, latency} = {2'b01, 4'h3};
        expQ = '{3'h5, 3'h5};
        {inputCommandDone, rxOverflow} = 2'b11;
        step(1);
        {inputCommandDone, rxOverflow} = 2'b00;
        for (int i = 0; i < 50 && !txFail; i++)
            step(1);
        {failNow, latency} = {1'b0, 4'h1};
        drain("overflow_retry");
        // analog threshold going above
        expQ = '{3'h3};
        analogResult[1] = 10'h300;
        drain("analog");
        // scheduled reports
        base = $urandom_range(1, 0);
        mult = $urandom_range(3, 2);
        {scheduleBaseRate, scheduleMultiplier} = {2'(base), 4'(mult)};
        scheduleContentSelect = 1'($urandom);
        expQ = '{3'h7, 3'h7, 3'h7, 3'h7};
        scheduleEnableBit = 1;
        drain("scheduled");
        scheduleEnableBit = 0;
        for (int i = 1; i < 4; i++)
            check("interval", schedT[i] - schedT[i - 1], (4 << base) * (mult + 1));
        step(200);
        drain("schedule_off");
        finish_test();
    end
endmodule
`default_nettype wire
